// ===== core/pco_pkg.sv
// Contract
// - Enable rise starts at first point, run set
// - Enable written zero stops, resets, clears run
// - Origin rise loads bias, then origin done
// - Origin written zero clears origin done
// - Adjust rise adds adjustment, then adjust done
// - Adjust written zero clears adjust done
// - Position scaled to configured counts per revolution
// - Absolute mode keeps position after point
// - Incremental mode zeroes position after point
// - Single mode stops after last point
// - Cyclic mode wraps to first point
// - Polarity selects idle and active level
// - Output type selects pulse or level
// - Pulse width 1 to 10000 times 100us
// - Fire early by delay compensation time
// - Points hold attribute and target, zero default
package pco_pkg;
   // ======================================
   // Register indices, byte address is index times four
   localparam logic [13:0] IDX_CTRL = 14'h30B0;
   localparam logic [13:0] IDX_ADJ = 14'h30B1;
   localparam logic [13:0] IDX_STATE = 14'h30C0;
   localparam logic [13:0] IDX_TGT = 14'h30C1;
   localparam logic [13:0] IDX_CURPOS = 14'h30C2;
   localparam logic [13:0] IDX_PT_BASE = 14'h3100;
   localparam logic [13:0] IDX_RES = 14'h3200;
   localparam logic [13:0] IDX_PPR = 14'h3201;
   localparam logic [13:0] IDX_MODE = 14'h3202;
   localparam logic [13:0] IDX_POL = 14'h3203;
   localparam logic [13:0] IDX_OTYPE = 14'h3204;
   localparam logic [13:0] IDX_PWIDTH = 14'h3205;
   localparam logic [13:0] IDX_DELAY = 14'h3206;
   localparam logic [13:0] IDX_BIAS = 14'h3207;
   localparam logic [13:0] IDX_NPTS = 14'h3208;
   localparam logic [13:0] IDX_IRQST = 14'h3209;
   localparam logic [13:0] IDX_IRQMSK = 14'h320A;
   localparam logic [13:0] IDX_POSHI = 14'h320B;
   // ======================================
   // Field positions
   localparam int CTRL_EN = 0;
   localparam int CTRL_ORG = 1;
   localparam int CTRL_ADJ = 2;
   localparam int MODE_INC = 0;
   localparam int MODE_CYC = 1;
   localparam int IRQ_MATCH = 0;
   localparam int IRQ_END = 1;
   localparam int IRQ_ORG = 2;
   localparam int IRQ_ADJ = 3;
   // ======================================
   // Sizes and reset values
   localparam int NPOINTS = 20;
   localparam logic [4:0] NPTS_MAX = 5'h14;
   localparam logic [15:0] RES_RST = 16'h2710;
   localparam logic [15:0] PPR_RST = 16'h2710;
   localparam logic [15:0] PWIDTH_RST = 16'h0001;
   localparam logic [15:0] PWIDTH_MAX = 16'h2710;
   // ======================================
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 100;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   // ======================================
   // Compare engine states
   typedef enum logic [2:0] {
      CS_OFF = 3'b001,
      CS_LOAD = 3'b010,
      CS_RUN = 3'b100
   } pco_cstate_type;
endpackage

// ===== core/pco_point_mem.sv
`timescale 1ns/1ps
module pco_point_mem import pco_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Write side
   input wire logic we_attr,
   input wire logic we_tgt,
   input wire logic [4:0] waddr,
   input wire logic [31:0] wdata,
   // Read side, data one cycle after address
   input wire logic [4:0] raddr,
   output logic [2:0] rattr,
   output logic [31:0] rtgt
);
   logic [2:0] attr_mem [NPOINTS];
   logic [31:0] tgt_mem [NPOINTS];

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < NPOINTS; i++) begin
            attr_mem[i] <= 3'h0;
            tgt_mem[i] <= 32'h0;
         end
      end else begin
         if (we_attr) begin
            attr_mem[waddr] <= wdata[2:0];
         end
         if (we_tgt) begin
            tgt_mem[waddr] <= wdata;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rattr <= 3'h0;
         rtgt <= 32'h0;
      end else begin
         rattr <= attr_mem[raddr];
         rtgt <= tgt_mem[raddr];
      end
   end
endmodule

// ===== core/pco_top.sv
`timescale 1ns/1ps
module pco_top import pco_pkg::*; #(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Encoder steps at native resolution
   input wire logic enc_step,
   input wire logic enc_dir,
   // Compare output and interrupt
   output logic compare_output_pin,
   output logic irq
);
   // ======================================
   // Decoding
   function automatic logic is_pt(input logic [13:0] a);
      return (a >= IDX_PT_BASE) && (a < IDX_PT_BASE + 14'(2 * NPOINTS));
   endfunction

   function automatic logic mapped(input logic [13:0] a);
      case (a)
         IDX_CTRL, IDX_ADJ, IDX_STATE, IDX_TGT, IDX_CURPOS,
         IDX_RES, IDX_PPR, IDX_MODE, IDX_POL, IDX_OTYPE, IDX_PWIDTH,
         IDX_DELAY, IDX_BIAS, IDX_NPTS, IDX_IRQST, IDX_IRQMSK,
         IDX_POSHI: mapped = 1'b1;
         default: mapped = is_pt(a);
      endcase
   endfunction

   logic [13:0] ridx;
   logic wr;
   logic [13:0] pt_off;
   logic wr_ctrl;
   logic [2:0] rise;
   logic [15:0] function_ctrl;
   logic [15:0] position_adjust_value;
   logic [15:0] position_resolution_setting;
   logic [15:0] enc_ppr;
   logic [15:0] compare_mode_setting;
   logic output_polarity_setting;
   logic output_type_setting;
   logic [15:0] pulse_width_setting;
   logic [15:0] delay_compensation_setting;
   logic [31:0] origin_bias_setting;
   logic [4:0] npts;
   logic [3:0] irq_st;
   logic [3:0] irq_mask;
   logic st_run;
   logic st_org;
   logic st_adj;
   logic [4:0] idx;
   logic signed [31:0] pos;
   logic [16:0] acc;
   logic [16:0] next_acc;
   logic scaled_step;
   pco_cstate_type cstate;
   logic [2:0] rattr;
   logic [31:0] rtgt;
   logic [31:0] rd_mux;
   logic [13:0] tick_cnt;
   logic tick;
   logic signed [15:0] win_cnt;
   logic signed [15:0] vel;
   logic signed [31:0] lead;
   logic signed [31:0] diff;
   logic prev_sgn;
   logic have_prev;
   logic hit;
   logic last;
   logic out_active;
   logic [15:0] pcnt;
   logic [13:0] psub;

   assign ridx = paddr[15:2];
   assign wr = psel && penable && pready && pwrite;
   assign pt_off = ridx - IDX_PT_BASE;
   assign wr_ctrl = wr && (ridx == IDX_CTRL);
   assign rise = pwdata[2:0] & ~function_ctrl[2:0] & {3{wr_ctrl}};
   assign last = (idx == npts - 5'h01);

   // ======================================
   // APB, one wait state so all answers come from flops
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0 : rd_mux;
            pslverr <= !mapped(ridx);
         end
      end
   end

   // Point table is write only; reads of it return zero
   always_comb begin
      case (ridx)
         IDX_CTRL: rd_mux = {16'h0, function_ctrl};
         IDX_ADJ: rd_mux = {16'h0, position_adjust_value};
         IDX_STATE: rd_mux = {29'h0, st_adj, st_org, st_run};
         IDX_TGT: rd_mux = {27'h0, idx};
         IDX_CURPOS: rd_mux = {16'h0, pos[15:0]};
         IDX_POSHI: rd_mux = {16'h0, pos[31:16]};
         IDX_RES: rd_mux = {16'h0, position_resolution_setting};
         IDX_PPR: rd_mux = {16'h0, enc_ppr};
         IDX_MODE: rd_mux = {16'h0, compare_mode_setting};
         IDX_POL: rd_mux = {31'h0, output_polarity_setting};
         IDX_OTYPE: rd_mux = {31'h0, output_type_setting};
         IDX_PWIDTH: rd_mux = {16'h0, pulse_width_setting};
         IDX_DELAY: rd_mux = {16'h0, delay_compensation_setting};
         IDX_BIAS: rd_mux = origin_bias_setting;
         IDX_NPTS: rd_mux = {27'h0, npts};
         IDX_IRQST: rd_mux = {28'h0, irq_st};
         IDX_IRQMSK: rd_mux = {28'h0, irq_mask};
         default: rd_mux = 32'h0;
      endcase
   end

   // ======================================
   // Configuration registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         function_ctrl <= 16'h0;
         position_adjust_value <= 16'h0;
         position_resolution_setting <= RES_RST;
         enc_ppr <= PPR_RST;
         compare_mode_setting <= 16'h0;
         output_polarity_setting <= 1'b0;
         output_type_setting <= 1'b0;
         pulse_width_setting <= PWIDTH_RST;
         delay_compensation_setting <= 16'h0;
         origin_bias_setting <= 32'h0;
         npts <= NPTS_MAX;
         irq_mask <= 4'h0;
      end else if (wr) begin
         case (ridx)
            IDX_CTRL: function_ctrl <= pwdata[15:0];
            IDX_ADJ: position_adjust_value <= pwdata[15:0];
            IDX_RES: position_resolution_setting <= pwdata[15:0];
            IDX_PPR: enc_ppr <= pwdata[15:0];
            IDX_MODE: compare_mode_setting <= pwdata[15:0];
            IDX_POL: output_polarity_setting <= pwdata[0];
            IDX_OTYPE: output_type_setting <= pwdata[0];
            IDX_PWIDTH: begin
               if (pwdata[15:0] != 16'h0 && pwdata[15:0] <= PWIDTH_MAX) begin
                  pulse_width_setting <= pwdata[15:0];
               end
            end
            IDX_DELAY: delay_compensation_setting <= pwdata[15:0];
            IDX_BIAS: origin_bias_setting <= pwdata;
            IDX_NPTS: begin
               if (pwdata[4:0] != 5'h0 && pwdata[4:0] <= NPTS_MAX) begin
                  npts <= pwdata[4:0];
               end
            end
            IDX_IRQMSK: irq_mask <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // ======================================
   // Point table
   pco_point_mem u_mem (
      .ref_clk(ref_clk),
      .srst(srst),
      .we_attr(wr && is_pt(ridx) && !pt_off[0]),
      .we_tgt(wr && is_pt(ridx) && pt_off[0]),
      .waddr(pt_off[5:1]),
      .wdata(pwdata),
      .raddr(idx),
      .rattr(rattr),
      .rtgt(rtgt)
   );

   // ======================================
   // Scaling; assumes resolution not above encoder counts
   // scale to resolution
   always_comb begin
      next_acc = acc + {1'b0, position_resolution_setting};
      scaled_step = enc_step && (next_acc >= {1'b0, enc_ppr});
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         acc <= 17'h0;
      end else if (enc_step) begin
         acc <= scaled_step ? next_acc - {1'b0, enc_ppr} : next_acc;
      end
   end

   // Origin beats adjust beats incremental zeroing beats steps
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pos <= 32'sh0;
      end else if (rise[CTRL_ORG]) begin
         pos <= origin_bias_setting;
      end else if (rise[CTRL_ADJ]) begin
         pos <= pos + {{16{position_adjust_value[15]}}, position_adjust_value};
      end else if (hit && compare_mode_setting[MODE_INC]) begin
         pos <= 32'sh0;
      end else if (scaled_step) begin
         pos <= enc_dir ? pos - 32'sh1 : pos + 32'sh1;
      end
   end

   // ======================================
   // Velocity per 100us window feeds the early-fire lead
   assign tick = (tick_cnt == 14'(TICK_CYCLES - 1));

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         tick_cnt <= 14'h0;
         win_cnt <= 16'sh0;
         vel <= 16'sh0;
      end else begin
         tick_cnt <= tick ? 14'h0 : tick_cnt + 14'h1;
         if (tick) begin
            vel <= win_cnt;
            win_cnt <= 16'sh0;
         end else if (scaled_step) begin
            win_cnt <= enc_dir ? win_cnt - 16'sh1 : win_cnt + 16'sh1;
         end
      end
   end

   always_comb begin
      lead = 32'(vel * $signed({1'b0, delay_compensation_setting}));
      diff = $signed(rtgt) - (pos + lead);
      hit = (cstate == CS_RUN) && ((diff == 32'sh0) || (have_prev && diff[31] != prev_sgn));
   end

   // ======================================
   // Compare sequencing
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cstate <= CS_OFF;
         idx <= 5'h0;
         st_run <= 1'b0;
         have_prev <= 1'b0;
         prev_sgn <= 1'b0;
      end else if (wr_ctrl && !pwdata[CTRL_EN]) begin
         cstate <= CS_OFF;
         idx <= 5'h0;
         st_run <= 1'b0;
         have_prev <= 1'b0;
      end else begin
         case (cstate)
            CS_OFF: begin
               if (rise[CTRL_EN]) begin
                  idx <= 5'h0;
                  st_run <= 1'b1;
                  cstate <= CS_LOAD;
               end
            end
            CS_LOAD: begin
               have_prev <= 1'b0;
               cstate <= CS_RUN;
            end
            CS_RUN: begin
               prev_sgn <= diff[31];
               have_prev <= 1'b1;
               if (hit) begin
                  cstate <= CS_LOAD;
                  if (!last) begin
                     idx <= idx + 5'h1;
                  end else if (compare_mode_setting[MODE_CYC]) begin
                     idx <= 5'h0;
                  end else begin
                     cstate <= CS_OFF;
                     st_run <= 1'b0;
                  end
               end
            end
            default: begin
               cstate <= CS_OFF;
               st_run <= 1'b0;
            end
         endcase
      end
   end

   // ======================================
   // Done flags
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_org <= 1'b0;
         st_adj <= 1'b0;
      end else if (wr_ctrl) begin
         if (rise[CTRL_ORG]) begin
            st_org <= 1'b1;
         end else if (!pwdata[CTRL_ORG]) begin
            st_org <= 1'b0;
         end
         if (rise[CTRL_ADJ]) begin
            st_adj <= 1'b1;
         end else if (!pwdata[CTRL_ADJ]) begin
            st_adj <= 1'b0;
         end
      end
   end

   // ======================================
   // Output driver; pulse times from its own counter so width is exact
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         out_active <= 1'b0;
         pcnt <= 16'h0;
         psub <= 14'h0;
      end else if (wr_ctrl && !pwdata[CTRL_EN]) begin
         out_active <= 1'b0;
         pcnt <= 16'h0;
      end else if (hit && rattr != 3'h0) begin
         if (!output_type_setting) begin
            out_active <= 1'b1;
            pcnt <= pulse_width_setting;
            psub <= 14'h0;
         end else begin
            out_active <= rattr[0];
         end
      end else if (pcnt != 16'h0) begin
         if (psub == 14'(TICK_CYCLES - 1)) begin
            psub <= 14'h0;
            pcnt <= pcnt - 16'h1;
            if (pcnt == 16'h1) begin
               out_active <= 1'b0;
            end
         end else begin
            psub <= psub + 14'h1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         compare_output_pin <= 1'b0;
      end else begin
         compare_output_pin <= out_active ^ output_polarity_setting;
      end
   end

   // ======================================
   // Interrupts; a new event wins over the clearing write
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq_st <= 4'h0;
         irq <= 1'b0;
      end else begin
         irq_st <= (irq_st & ~((wr && ridx == IDX_IRQST) ? pwdata[3:0] : 4'h0))
                   | {rise[CTRL_ADJ], rise[CTRL_ORG], hit && last, hit};
         irq <= |(irq_st & irq_mask);
      end
   end

   // ======================================
   // Checks
   property p_start;
      @(posedge ref_clk) disable iff (srst)
      rise[CTRL_EN] && cstate == CS_OFF |=> st_run && idx == 5'h0 ##1 cstate == CS_RUN;
   endproperty
   a_start: assert property (p_start) else $error("enable did not start");

   property p_stop;
      @(posedge ref_clk) disable iff (srst)
      wr_ctrl && !pwdata[CTRL_EN] |=> !st_run && cstate == CS_OFF && idx == 5'h0;
   endproperty
   a_stop: assert property (p_stop) else $error("disable did not stop");

   property p_org;
      @(posedge ref_clk) disable iff (srst)
      rise[CTRL_ORG] |=> pos == $past(origin_bias_setting) && st_org;
   endproperty
   a_org: assert property (p_org) else $error("origin load failed");

   property p_orgclr;
      @(posedge ref_clk) disable iff (srst)
      wr_ctrl && !pwdata[CTRL_ORG] |=> !st_org;
   endproperty
   a_orgclr: assert property (p_orgclr) else $error("origin done not cleared");

   property p_adj;
      @(posedge ref_clk) disable iff (srst)
      rise[CTRL_ADJ] && !rise[CTRL_ORG] |=>
         pos == $past(pos) + {{16{$past(position_adjust_value[15])}}, $past(position_adjust_value)} && st_adj;
   endproperty
   a_adj: assert property (p_adj) else $error("adjust failed");

   property p_inc;
      @(posedge ref_clk) disable iff (srst)
      hit && compare_mode_setting[MODE_INC] && rise[2:1] == 2'b00 |=> pos == 32'sh0;
   endproperty
   a_inc: assert property (p_inc) else $error("incremental not zeroed");

   property p_single;
      @(posedge ref_clk) disable iff (srst)
      hit && last && !compare_mode_setting[MODE_CYC] && !wr_ctrl |=> !st_run ##2 cstate == CS_OFF;
   endproperty
   a_single: assert property (p_single) else $error("single mode kept running");

   property p_cyc;
      @(posedge ref_clk) disable iff (srst)
      hit && last && compare_mode_setting[MODE_CYC] && !wr_ctrl |=> st_run && idx == 5'h0;
   endproperty
   a_cyc: assert property (p_cyc) else $error("cyclic did not wrap");

   property p_level;
      @(posedge ref_clk) disable iff (srst)
      hit && output_type_setting && rattr != 3'h0 && !wr_ctrl |=>
         ##1 compare_output_pin == ($past(rattr[0], 2) ^ output_polarity_setting);
   endproperty
   a_level: assert property (p_level) else $error("level output wrong");

   c_hit: cover property (@(posedge ref_clk) disable iff (srst) hit);
   c_wrap: cover property (@(posedge ref_clk) disable iff (srst) hit && last && compare_mode_setting[MODE_CYC]);
   c_pulse: cover property (@(posedge ref_clk) disable iff (srst) out_active && pcnt == 16'h1);
endmodule

// ===== sim/pco_term_model.sv
`timescale 1ns/1ps
// ======================================
// Terminal device that receives the compare output
module pco_term_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Compare output and the level it rests at
   input wire logic compare_output_pin,
   input wire logic idle_level,
   // Observed activity
   output int pulses,
   output int width
);
   int run;
   // idle level tracked
   // Width counts sampled active edges, so a glitch shorter than a cycle is not seen
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         run <= 0;
         pulses <= 0;
         width <= 0;
      end else if (compare_output_pin !== idle_level) begin
         run <= run + 1;
         if (run == 0) begin
            pulses <= pulses + 1;
         end
      end else begin
         if (run != 0) begin
            width <= run;
         end
         run <= 0;
      end
   end
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top import pco_pkg::*;;
   // ======================================
   // Signals
   logic ref_clk = 1'h0;
   logic srst = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic enc_step = 1'h0;
   logic enc_dir = 1'h0;
   logic idle_lvl = 1'h0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, pin, irq;
   int err_count = 0;
   int check_count = 0;
   int pulses, width;
   always #5 ref_clk = ~ref_clk;
   // Short tick keeps pulse widths at a few cycles
   pco_top #(.TICK_CYCLES(10)) dut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .enc_step(enc_step), .enc_dir(enc_dir), .compare_output_pin(pin), .irq(irq));
   pco_term_model term (.ref_clk(ref_clk), .srst(srst), .compare_output_pin(pin),
      .idle_level(idle_lvl), .pulses(pulses), .width(width));
   // ======================================
   // Shared tasks
   task wrap_up;
      $display("Checks %0d, errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [13:0] idx, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         err_count++;
         $display("Error at %0t: bus timeout", $time);
         wrap_up();
      end
   endtask
   task wr(input logic [13:0] i, input logic [31:0] d);
      apb(1'h1, i, d);
   endtask
   task rd(input logic [13:0] i, input logic [31:0] e);
      apb(1'h0, i, 32'h0);
      chk(rdat, e);
   endtask
   // Output and interrupt lag the write edge by two flops
   task settle;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask
   task steps(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         enc_step <= 1'h1;
         @(posedge ref_clk);
         enc_step <= 1'h0;
         repeat (18) @(posedge ref_clk);
      end
   endtask
   // ======================================
   // Scenarios
   task t_reset;
      rd(IDX_STATE, 32'h0);
      rd(IDX_TGT, 32'h0);
      rd(IDX_CURPOS, 32'h0);
      rd(IDX_RES, 32'h2710);
      rd(IDX_PWIDTH, 32'h1);
      rd(IDX_NPTS, 32'h14);
      apb(1'h0, 14'h0005, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk({31'h0, pin}, 32'h0);
   endtask
   task t_origin_adjust;
      wr(IDX_BIAS, 32'h64);
      wr(IDX_CTRL, 32'h2);
      rd(IDX_STATE, 32'h2);
      rd(IDX_CURPOS, 32'h64);
      wr(IDX_CTRL, 32'h0);
      rd(IDX_STATE, 32'h0);
      wr(IDX_ADJ, 32'h5);
      wr(IDX_CTRL, 32'h4);
      // Second write of the same value must not add again
      wr(IDX_CTRL, 32'h4);
      rd(IDX_CURPOS, 32'h69);
      rd(IDX_STATE, 32'h4);
      wr(IDX_CTRL, 32'h0);
      rd(IDX_STATE, 32'h0);
      rd(IDX_IRQST, 32'hC);
      chk({31'h0, irq}, 32'h0);
      wr(IDX_IRQMSK, 32'h4);
      settle();
      chk({31'h0, irq}, 32'h1);
      wr(IDX_IRQST, 32'hC);
      settle();
      chk({31'h0, irq}, 32'h0);
      rd(IDX_IRQST, 32'h0);
   endtask
   task t_single_abs;
      wr(IDX_RES, 32'h5);
      wr(IDX_PPR, 32'hA);
      wr(IDX_NPTS, 32'h2);
      wr(IDX_PT_BASE, 32'h1);
      wr(IDX_PT_BASE + 14'h1, 32'h6E);
      wr(IDX_PT_BASE + 14'h2, 32'h1);
      wr(IDX_PT_BASE + 14'h3, 32'h73);
      wr(IDX_CTRL, 32'h1);
      rd(IDX_STATE, 32'h1);
      rd(IDX_TGT, 32'h0);
      steps(20);
      rd(IDX_STATE, 32'h0);
      rd(IDX_CURPOS, 32'h73);
      chk(pulses, 32'h2);
      chk(width, 32'hA);
      rd(IDX_IRQST, 32'h3);
   endtask
   task t_cyclic_inc;
      wr(IDX_IRQST, 32'hF);
      wr(IDX_POL, 32'h1);
      idle_lvl <= 1'h1;
      settle();
      chk({31'h0, pin}, 32'h1);
      wr(IDX_OTYPE, 32'h1);
      wr(IDX_MODE, 32'h3);
      wr(IDX_PT_BASE + 14'h1, 32'h3);
      wr(IDX_PT_BASE + 14'h2, 32'h2);
      wr(IDX_PT_BASE + 14'h3, 32'h3);
      wr(IDX_BIAS, 32'h0);
      wr(IDX_CTRL, 32'h2);
      wr(IDX_CTRL, 32'h1);
      steps(6);
      settle();
      chk({31'h0, pin}, 32'h0);
      rd(IDX_CURPOS, 32'h0);
      rd(IDX_TGT, 32'h1);
      steps(6);
      settle();
      chk({31'h0, pin}, 32'h1);
      rd(IDX_TGT, 32'h0);
      rd(IDX_STATE, 32'h1);
      steps(6);
      wr(IDX_CTRL, 32'h0);
      settle();
      chk({31'h0, pin}, 32'h1);
      rd(IDX_STATE, 32'h0);
      rd(IDX_TGT, 32'h0);
   endtask
   // A fast move must fire ahead of the target by the lead
   task t_lead;
      int n;
      wr(IDX_PWIDTH, 32'h0);
      rd(IDX_PWIDTH, 32'h1);
      wr(IDX_MODE, 32'h0);
      wr(IDX_NPTS, 32'h1);
      wr(IDX_PT_BASE + 14'h1, 32'h1F4);
      wr(IDX_PPR, 32'h5);
      wr(IDX_DELAY, 32'hA);
      wr(IDX_CTRL, 32'h1);
      enc_step <= 1'h1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pin !== 1'h0 && n < 700);
      enc_step <= 1'h0;
      if (pin !== 1'h0) begin
         err_count++;
         $display("Error at %0t: compare output never fired", $time);
         wrap_up();
      end else begin
         apb(1'h0, IDX_CURPOS, 32'h0);
         chk({30'h0, rdat >= 32'h190, rdat < 32'h1F4}, 32'h3);
         rd(IDX_STATE, 32'h0);
         rd(IDX_POSHI, 32'h0);
      end
   endtask
   // ======================================
   // Main sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      srst <= 1'h0;
      t_reset();
      t_origin_adjust();
      t_single_abs();
      t_cyclic_inc();
      t_lead();
      wrap_up();
   end
endmodule
